// File: hw/ftc_pkg.sv
package ftc_pkg;
  // register byte offsets
  localparam logic [11:0] FTC_CFG_OFFS = 12'h400;
  localparam logic [11:0] FTC_TAP0_OFFS = 12'h418;
  localparam logic [11:0] FTC_TAP1_OFFS = 12'h41A;
  localparam logic [11:0] FTC_TAP2_OFFS = 12'h41C;
  localparam logic [11:0] FTC_TAP3_OFFS = 12'h41E;
  localparam logic [11:0] FTC_CENTER_OFFS = 12'h420;
  localparam logic [11:0] FTC_TAP5_OFFS = 12'h423;
  // field widths and positions
  localparam int FTC_SIDE_W = 12;
  localparam int FTC_CENTER_W = 18;
  localparam int FTC_NUM_SIDE = 5;
  localparam int FTC_SCW_LSB = 2;
  localparam int FTC_SCW_MSB = 4;
  localparam int FTC_MERGE_BIT = 5;
  localparam int FTC_SHARE_BIT = 6;
  localparam logic [2:0] FTC_SCW_MAX = 3'h6;
  localparam int FTC_SCW_BIAS = 16;
  // reset values
  localparam logic [11:0] FTC_SIDE_RST = 12'h000;
  localparam logic [17:0] FTC_CENTER_RST = 18'h00000;
  localparam logic [7:0] FTC_CFG_RST = 8'h00;
  localparam logic [23:0] FTC_RD_ZERO = 24'h000000;
endpackage

// File: hw/ftc_sel.sv
`timescale 1ns/100ps
// picks the coefficient source for the B filter
module ftc_sel
  import ftc_pkg::*;
#(
  parameter int W = 12
) (
  // selection
  input wire logic share,
  // sources
  input wire logic [W-1:0] a_coef,
  input wire logic [W-1:0] b_coef,
  // result
  output logic [W-1:0] y
);
  // share set means B follows the A set
  assign y = share ? a_coef : b_coef;
endmodule

// File: hw/ftc_bank.sv
// The plain strobed port was chosen for this implementation.
`timescale 1ns/100ps
// Summary of operation
// - the first side coefficient holds a 12-bit signed value for tap one of filter A or merged.
// - the second side coefficient holds a 12-bit signed value for tap two.
// - the third side coefficient holds a 12-bit signed value for tap three.
// - the fourth side coefficient holds a 12-bit signed value for tap four.
// - the center coefficient holds an 18-bit signed value, wider than the side taps.
// - the center register spans 24 bits with six reserved upper bits, all zero after reset.
// - a 3-bit weight from 0 to 6 sets the side tap step to two to the weight minus sixteen.
// - with sharing set the B filter uses the A side taps 0..3 and center, else its own; tap5 is not switched.
// - with merge set both filters act as one over one stream; software sets it for single mode.
module ftc_bank
  import ftc_pkg::*;
#(
  parameter int SIDE_W = FTC_SIDE_W,
  parameter int CENTER_W = FTC_CENTER_W
) (
  // clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // register port
  input wire logic [11:0] ADDR,
  input wire logic [23:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [23:0] RDATA,
  // serial link state, for write protection
  input wire logic SERIAL_LINK_ENABLE,
  // B channel own coefficients from elsewhere
  input wire logic [SIDE_W*4-1:0] B_SIDE_COEF,
  input wire logic [CENTER_W-1:0] B_CENTER_COEF,
  // coefficients to the A filter
  output logic [SIDE_W*4-1:0] A_SIDE_COEF,
  output logic [CENTER_W-1:0] A_CENTER_COEF,
  output logic [SIDE_W-1:0] A_TAP5_COEF,
  // coefficients to the B filter
  output logic [SIDE_W*4-1:0] B_SIDE_USE,
  output logic [CENTER_W-1:0] B_CENTER_USE,
  // filter controls and the write refusal flag
  output logic [2:0] SIDE_COEF_WEIGHT,
  output logic [4:0] SIDE_LSB_EXP,
  output logic FILTER_MERGE_ENABLE,
  output logic COEF_SHARE_ENABLE,
  output logic WRITE_REFUSED
);
  // the read layout pads to 24 bits and fixes six reserved center bits,
  // so other widths cannot be served
  if (SIDE_W != FTC_SIDE_W || CENTER_W != FTC_CENTER_W) begin : g_bad_width
    $error("ftc_bank: coefficient widths are fixed by the register layout");
  end
  // the weight ports are three bits wide
  if (FTC_SCW_MSB - FTC_SCW_LSB != 2) begin : g_bad_weight
    $error("ftc_bank: the weight field must be three bits wide");
  end

  // storage is plain flip-flops; a new coefficient reaches the filter the cycle
  // after its write with no staging, which is why live-link writes are dropped
  // side coefficient storage, index 0..4 maps taps 0..3 and tap5
  logic [SIDE_W-1:0] side_reg [FTC_NUM_SIDE];
  logic [CENTER_W-1:0] center_reg;
  logic [7:0] cfg_reg;
  logic [7:0] cfg_next;
  logic refused_reg;
  logic [23:0] rdata_reg;
  logic [23:0] rdata_next;
  // write qualifiers and address decode results
  logic wr_ok;
  logic wr_drop;
  int side_sel;
  logic side_hit;
  logic [2:0] side_idx;
  logic [FTC_NUM_SIDE-1:0] side_wr_sel;
  logic center_wr_sel;
  logic cfg_wr_sel;

  // address decode shared by write and read paths
  function automatic int side_index(input logic [11:0] a);
    case (a)
      FTC_TAP0_OFFS: side_index = 0;
      FTC_TAP1_OFFS: side_index = 1;
      FTC_TAP2_OFFS: side_index = 2;
      FTC_TAP3_OFFS: side_index = 3;
      FTC_TAP5_OFFS: side_index = 4;
      default: side_index = -1;
    endcase
  endfunction

  // clamp a weight code to the largest step the filter supports
  function automatic logic [2:0] weight_clamp(input logic [2:0] w);
    if (w > FTC_SCW_MAX) begin
      weight_clamp = FTC_SCW_MAX;
    end else begin
      weight_clamp = w;
    end
  endfunction

  // writes while the link runs would glitch live samples, so they are dropped
  assign wr_ok = WR && !SERIAL_LINK_ENABLE;
  assign wr_drop = WR && SERIAL_LINK_ENABLE;

  // one decode feeds every side tap select; the index is cut to three bits on purpose
  assign side_sel = side_index(ADDR);
  assign side_hit = (side_sel >= 0);
  assign side_idx = side_hit ? 3'(side_sel) : 3'h0;
  assign center_wr_sel = wr_ok && (ADDR == FTC_CENTER_OFFS);
  assign cfg_wr_sel = wr_ok && (ADDR == FTC_CFG_OFFS);

  // one write select per side tap
  always_comb begin
    side_wr_sel = {FTC_NUM_SIDE{1'b0}};
    for (int i = 0; i < FTC_NUM_SIDE; i++) begin
      side_wr_sel[i] = wr_ok && side_hit && (side_idx == 3'(i));
    end
  end

  // side taps, 12-bit signed, reserved bits 15:12 not stored
  genvar gi;
  generate
    for (gi = 0; gi < FTC_NUM_SIDE; gi++) begin : g_side
      always_ff @(posedge CLK) begin
        if (SYS_RST) begin
          side_reg[gi] <= FTC_SIDE_RST;
        end else if (side_wr_sel[gi]) begin
          side_reg[gi] <= WDATA[SIDE_W-1:0];
        end
      end
    end
  endgenerate

  // center tap, 18 bits; upper six reserved bits are not stored and read zero
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      center_reg <= FTC_CENTER_RST;
    end else if (center_wr_sel) begin
      center_reg <= WDATA[CENTER_W-1:0];
    end
  end

  // configuration next value; an out-of-range weight is clamped rather than refused
  always_comb begin
    cfg_next = cfg_reg;
    if (cfg_wr_sel) begin
      cfg_next = WDATA[7:0];
      cfg_next[FTC_SCW_MSB:FTC_SCW_LSB] = weight_clamp(WDATA[FTC_SCW_MSB:FTC_SCW_LSB]);
    end
  end

  // configuration: weight, merge, share and the unused mode bits
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      cfg_reg <= FTC_CFG_RST;
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  // sticky flag for a write dropped during link activity; set wins over clear
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      refused_reg <= 1'b0;
    end else if (wr_drop) begin
      refused_reg <= 1'b1;
    end else if (cfg_wr_sel) begin
      refused_reg <= 1'b0;
    end
  end

  // read mux; idle cycles and unmapped places give zero, so data stand one cycle
  always_comb begin
    rdata_next = FTC_RD_ZERO;
    if (RD) begin
      if (side_hit) begin
        rdata_next = {{(24-SIDE_W){1'b0}}, side_reg[side_idx]};
      end else if (ADDR == FTC_CENTER_OFFS) begin
        rdata_next = {6'h00, center_reg};
      end else if (ADDR == FTC_CFG_OFFS) begin
        rdata_next = {16'h0000, 1'b0, cfg_reg[6:0]};
      end
    end
  end

  // registered read data, as the bus expects it one cycle after the strobe
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      rdata_reg <= FTC_RD_ZERO;
    end else begin
      rdata_reg <= rdata_next;
    end
  end
  assign RDATA = rdata_reg;

  // A filter taps; outputs come straight from the storage flip-flops
  generate
    for (gi = 0; gi < 4; gi++) begin : g_aout
      assign A_SIDE_COEF[gi*SIDE_W +: SIDE_W] = side_reg[gi];
    end
  endgenerate
  assign A_CENTER_COEF = center_reg;
  // tap5 travels on its own port; the B set for it lives outside this block
  assign A_TAP5_COEF = side_reg[4];

  // weight field as stored, always within 0..6 after the clamp
  assign SIDE_COEF_WEIGHT = cfg_reg[FTC_SCW_MSB:FTC_SCW_LSB];
  // exponent magnitude is sixteen minus the weight, so the lsb weighs 2^-exp
  assign SIDE_LSB_EXP = 5'(FTC_SCW_BIAS) - {2'b00, cfg_reg[FTC_SCW_MSB:FTC_SCW_LSB]};
  // mode controls handed to the filter datapath
  assign FILTER_MERGE_ENABLE = cfg_reg[FTC_MERGE_BIT];
  assign COEF_SHARE_ENABLE = cfg_reg[FTC_SHARE_BIT];
  // sticky refusal flag, cleared by the next accepted configuration write
  assign WRITE_REFUSED = refused_reg;

  // B filter source selection; a plain mux, so sharing switches in the same cycle
  // side taps 0..3 as one bus
  ftc_sel #(.W(SIDE_W*4)) u_sel_side (
    .share(cfg_reg[FTC_SHARE_BIT]),
    .a_coef(A_SIDE_COEF),
    .b_coef(B_SIDE_COEF),
    .y(B_SIDE_USE)
  );
  // center tap
  ftc_sel #(.W(CENTER_W)) u_sel_center (
    .share(cfg_reg[FTC_SHARE_BIT]),
    .a_coef(center_reg),
    .b_coef(B_CENTER_COEF),
    .y(B_CENTER_USE)
  );
endmodule

// File: tb/ftc_bank_assertions.sv
`timescale 1ns/100ps
// port checker for the coefficient bank
module ftc_chk (
  // clock, reset, register port
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic [11:0] ADDR,
  input wire logic [23:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [23:0] RDATA,
  input wire logic SERIAL_LINK_ENABLE,
  // coefficients and controls
  input wire logic [47:0] B_SIDE_COEF,
  input wire logic [47:0] A_SIDE_COEF,
  input wire logic [17:0] A_CENTER_COEF,
  input wire logic [47:0] B_SIDE_USE,
  input wire logic [17:0] B_CENTER_COEF,
  input wire logic [17:0] B_CENTER_USE,
  input wire logic [2:0] SIDE_COEF_WEIGHT,
  input wire logic [4:0] SIDE_LSB_EXP,
  input wire logic FILTER_MERGE_ENABLE,
  input wire logic COEF_SHARE_ENABLE,
  input wire logic WRITE_REFUSED
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  // a write that the link state lets through
  wire acc = WR && !SERIAL_LINK_ENABLE;
  tap0_store_a: assert property (acc && ADDR == 12'h418 |=>
    A_SIDE_COEF[11:0] == $past(WDATA[11:0])) else $error("tap0 bad");
  tap1_store_a: assert property (acc && ADDR == 12'h41A |=>
    A_SIDE_COEF[23:12] == $past(WDATA[11:0])) else $error("tap1 bad");
  tap2_store_a: assert property (acc && ADDR == 12'h41C |=>
    A_SIDE_COEF[35:24] == $past(WDATA[11:0])) else $error("tap2 bad");
  tap3_store_a: assert property (acc && ADDR == 12'h41E |=>
    A_SIDE_COEF[47:36] == $past(WDATA[11:0])) else $error("tap3 bad");
  center_store_a: assert property (acc && ADDR == 12'h420 |=>
    A_CENTER_COEF == $past(WDATA[17:0])) else $error("center bad");
  center_rsvd_a: assert property (RD && ADDR == 12'h420 |=>
    RDATA[23:18] == 6'h00) else $error("reserved bits set");
  weight_exp_a: assert property (SIDE_COEF_WEIGHT <= 3'h6 &&
    SIDE_LSB_EXP == 5'h10 - SIDE_COEF_WEIGHT) else $error("weight bad");
  share_mux_a: assert property (B_SIDE_USE ==
    (COEF_SHARE_ENABLE ? A_SIDE_COEF : B_SIDE_COEF)) else $error("share bad");
  merge_store_a: assert property (acc && ADDR == 12'h400 |=>
    FILTER_MERGE_ENABLE == $past(WDATA[5])) else $error("merge bad");
  share_center_a: assert property (B_CENTER_USE ==
    (COEF_SHARE_ENABLE ? A_CENTER_COEF : B_CENTER_COEF)) else $error("center share bad");
  refused_hold_a: assert property (WR && SERIAL_LINK_ENABLE |=>
    WRITE_REFUSED && $stable(A_SIDE_COEF) && $stable(A_CENTER_COEF))
    else $error("refused write landed");
endmodule

bind ftc_bank ftc_chk i_chk (.*);

// File: tb/fir_tap_coef_bank_a_test.sv
`timescale 1ns/100ps
// register-level test of the tap coefficient bank
module fir_tap_coef_bank_a_test;
  logic CLK = 1'b0;
  logic SYS_RST = 1'b1;
  logic [11:0] ADDR = 12'h000;
  logic [23:0] WDATA = 24'h000000;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic SERIAL_LINK_ENABLE = 1'b0;
  logic [47:0] B_SIDE_COEF = 48'h5A5C3C1E0F00;
  logic [17:0] B_CENTER_COEF = 18'h2A5A5;
  logic [23:0] RDATA;
  logic [47:0] A_SIDE_COEF, B_SIDE_USE;
  logic [17:0] A_CENTER_COEF, B_CENTER_USE;
  logic [11:0] A_TAP5_COEF;
  logic [2:0] SIDE_COEF_WEIGHT;
  logic [4:0] SIDE_LSB_EXP;
  logic FILTER_MERGE_ENABLE, COEF_SHARE_ENABLE, WRITE_REFUSED;
  int error_cnt = 0;
  int comparisons = 0;
  int cyc = 0;
  logic [11:0] offs [6] = '{12'h418, 12'h41A, 12'h41C, 12'h41E, 12'h420, 12'h423};
  ftc_bank i_dut (.*);
  always #2.5 CLK = ~CLK;
  // ceiling well above the roughly ninety cycles the sequence needs
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      error_cnt++;
      stop_test();
    end
  end
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one-cycle strobes; #1 lets the taking edge's updates land
  task automatic wr(input logic [11:0] a, input logic [23:0] d);
    @(posedge CLK);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= d;
    @(posedge CLK);
    WR <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [11:0] a, input logic [23:0] exp);
    @(posedge CLK);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge CLK);
    RD <= 1'b0;
    #1;
    chk({24'h0, RDATA}, {24'h0, exp});
  endtask
  task stop_test();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge CLK);
    SYS_RST <= 1'b0;
    // reset values, then an unmapped place
    for (int i = 0; i < 6; i++) rd(offs[i], 24'h000000);
    rd(12'h500, 24'h000000);
    // side taps keep twelve bits only
    for (int i = 0; i < 4; i++) begin
      wr(offs[i], 24'hABC800 + 24'(i));
      rd(offs[i], 24'h000800 + 24'(i));
    end
    chk(A_SIDE_COEF, 48'h803802801800);
    wr(12'h420, 24'hFFFFFF);
    rd(12'h420, 24'h03FFFF);
    chk({30'h0, A_CENTER_COEF}, 48'h00000003FFFF);
    // tap5 is a side tap on a port of its own
    wr(12'h423, 24'hFFFA55);
    rd(12'h423, 24'h000A55);
    chk({36'h0, A_TAP5_COEF}, 48'h000000000A55);
    // every weight code, and 7 which must clamp
    for (int w = 0; w < 8; w++) begin
      wr(12'h400, {19'h0, 3'(w), 2'h0});
      chk({43'h0, SIDE_LSB_EXP}, 48'(16 - (w > 6 ? 6 : w)));
      chk({45'h0, SIDE_COEF_WEIGHT}, 48'(w > 6 ? 6 : w));
    end
    wr(12'h400, 24'h000040);
    chk(B_SIDE_USE, 48'h803802801800);
    chk({30'h0, B_CENTER_USE}, 48'h00000003FFFF);
    chk({47'h0, COEF_SHARE_ENABLE}, 48'h1);
    wr(12'h400, 24'h000020);
    chk(B_SIDE_USE, 48'h5A5C3C1E0F00);
    chk({30'h0, B_CENTER_USE}, 48'h00000002A5A5);
    chk({47'h0, COEF_SHARE_ENABLE}, 48'h0);
    chk({47'h0, FILTER_MERGE_ENABLE}, 48'h1);
    rd(12'h400, 24'h000020);
    // a live link drops the write
    @(posedge CLK);
    SERIAL_LINK_ENABLE <= 1'b1;
    wr(12'h418, 24'h000123);
    rd(12'h418, 24'h000800);
    chk({47'h0, WRITE_REFUSED}, 48'h1);
    chk(A_SIDE_COEF, 48'h803802801800);
    // a second reset in mid-run clears every register again
    @(posedge CLK);
    SYS_RST <= 1'b1;
    SERIAL_LINK_ENABLE <= 1'b0;
    repeat (12) @(posedge CLK);
    SYS_RST <= 1'b0;
    rd(12'h420, 24'h000000);
    chk({30'h0, A_CENTER_COEF}, 48'h0);
    chk({47'h0, WRITE_REFUSED}, 48'h0);
    chk({47'h0, FILTER_MERGE_ENABLE}, 48'h0);
    stop_test();
  end
endmodule
